// [rtl/pit_bus_if.sv]
// byte-wide port bus between host controller and timer device
`timescale 1ns/1ns
interface pit_bus_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       port_select_lo;
  logic       port_select_hi;
  logic [7:0] hdata;
  logic       hdata_oe;
  logic [7:0] ddata;
  logic       ddata_oe;
  logic [7:0] data;

  // undriven bus floats high, as with a pull-up
  assign data = hdata_oe ? hdata : (ddata_oe ? ddata : 8'hff);

  modport host (
    output cs_n, rd_n, wr_n, port_select_lo, port_select_hi, hdata, hdata_oe,
    input  data
  );
  modport dev (
    input  cs_n, rd_n, wr_n, port_select_lo, port_select_hi, data,
    output ddata, ddata_oe
  );
endinterface

// [rtl/pit_device.sv]
// three-channel interval timer device end
`timescale 1ns/1ns
module pit_device (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  pit_bus_if.dev          bus,
  input  wire logic [2:0] ctr_clk_i,
  input  wire logic [2:0] gate_i,
  output logic      [2:0] ctr_out_o
);
  typedef struct packed {
    pit_pkg::pit_chan_s [2:0] ch;
    logic [2:0]               cclk_prev;
    logic                     wr_prev;
    logic                     rd_prev;
    logic [7:0]               dout;
    logic                     doe;
  } pit_dev_s;

  pit_dev_s   q;
  pit_dev_s   d;
  logic [5:0] pins_s;

  // decrement in binary or four-decade decimal; zero wraps to the top
  function automatic logic [15:0] dec_f(input logic [15:0] v,
                                        input logic        bcd,
                                        input logic [1:0]  step);
    logic [15:0] r;
    logic [4:0]  dig;
    logic [4:0]  brw;
    r   = v - {14'h0, step};
    brw = {3'h0, step};
    if (bcd) begin
      for (int k = 0; k < 4; k++) begin
        dig = {1'b0, v[4*k +: 4]} - brw;
        if (dig[4]) begin
          dig = dig + 5'h0a;
          brw = 5'h01;
        end else begin
          brw = 5'h00;
        end
        r[4*k +: 4] = dig[3:0];
      end
    end
    return r;
  endfunction

  // pins come from other clocks: synchronised before any use
  pit_sync #(
    .W(6)
  ) pit_sync_inst (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({gate_i, ctr_clk_i}),
    .q_o       (pins_s)
  );

  always_comb begin
    pit_pkg::pit_chan_s c;
    logic [1:0]  sel;
    logic [1:0]  pick;
    logic [2:0]  mnew;
    logic        wr_act;
    logic        rd_act;
    logic        wr_go;
    logic        rd_go;
    logic        rise;
    logic        fall;
    logic        g;
    logic        ld;
    logic        done;
    logic        last;
    logic        trig_mode;
    logic [1:0]  step;
    logic [15:0] nxt;
    logic [15:0] v;
    c         = '0;
    d         = q;
    sel       = {bus.port_select_hi, bus.port_select_lo};
    pick      = bus.data[pit_pkg::CW_PICK_LSB +: 2];
    mnew      = bus.data[pit_pkg::CW_MODE_LSB +: 3];
    wr_act    = !bus.cs_n && !bus.wr_n;
    rd_act    = !bus.cs_n && !bus.rd_n;
    wr_go     = wr_act && !q.wr_prev;
    rd_go     = rd_act && !q.rd_prev;
    rise      = 1'b0;
    fall      = 1'b0;
    g         = 1'b0;
    ld        = 1'b0;
    done      = 1'b0;
    last      = 1'b0;
    trig_mode = 1'b0;
    step      = 2'h1;
    nxt       = '0;
    v         = '0;
    if (mnew[1]) begin
      mnew[2] = 1'b0;
    end
    d.wr_prev   = wr_act;
    d.rd_prev   = rd_act;
    d.cclk_prev = pins_s[2:0];
    if (!rd_act) begin
      d.doe = 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      c    = q.ch[i];
      rise = pins_s[i] && !q.cclk_prev[i];
      fall = !pins_s[i] && q.cclk_prev[i];
      g    = pins_s[3+i];
      trig_mode = (c.mode == pit_pkg::MODE_ONESHT) || (c.mode == pit_pkg::MODE_RATE) ||
                  (c.mode == pit_pkg::MODE_SQUARE) || (c.mode == pit_pkg::MODE_HWSTRB);
      if (rise) begin
        if (g && !c.gate) begin
          c.trig = 1'b1;
        end
        c.gate = g;
        if (c.ld_pend) begin
          c.ld_rise = 1'b1;
        end
      end
      if (fall) begin
        ld = c.ld_pend && c.ld_rise;
        if (ld) begin
          c.ld_pend = 1'b0;
          c.ld_rise = 1'b0;
          c.have    = 1'b1;
        end
        // strobe lasts exactly one counter clock
        if ((c.mode == pit_pkg::MODE_SWSTRB) || (c.mode == pit_pkg::MODE_HWSTRB)) begin
          c.out = 1'b1;
        end
        if (c.trig && trig_mode && c.have) begin
          c.cnt   = c.init;
          c.run   = 1'b1;
          c.first = 1'b1;
          if (c.mode == pit_pkg::MODE_ONESHT) begin
            c.out = 1'b0;
          end
        end else if (ld && (c.mode != pit_pkg::MODE_ONESHT) &&
                     (c.mode != pit_pkg::MODE_HWSTRB) &&
                     ((c.mode == pit_pkg::MODE_TCINT) || (c.mode == pit_pkg::MODE_SWSTRB) ||
                      !c.run)) begin
          c.cnt   = c.init;
          c.run   = 1'b1;
          c.first = 1'b1;
          if (c.mode == pit_pkg::MODE_TCINT) begin
            c.out = 1'b0;
          end
        end else if (c.run && (c.gate || (c.mode == pit_pkg::MODE_ONESHT) ||
                               (c.mode == pit_pkg::MODE_HWSTRB))) begin
          if (c.mode == pit_pkg::MODE_SQUARE) begin
            step = 2'h2;
            if (c.first && c.init[0]) begin
              step = c.out ? 2'h1 : 2'h3;
            end
            if ((c.cnt == {14'h0, step}) || ((c.cnt != 16'h0) && (c.cnt < {14'h0, step}))) begin
              c.out   = !c.out;
              c.cnt   = c.init;
              c.first = 1'b1;
            end else begin
              c.cnt   = dec_f(c.cnt, c.bcd, step);
              c.first = 1'b0;
            end
          end else begin
            nxt = dec_f(c.cnt, c.bcd, 2'h1);
            if (c.mode == pit_pkg::MODE_RATE) begin
              // low for the one clock spent at a count of one
              if (c.cnt == 16'h1) begin
                c.cnt = c.init;
                c.out = 1'b1;
              end else begin
                c.cnt = nxt;
                c.out = (nxt != 16'h1);
              end
            end else begin
              c.cnt = nxt;
              if (nxt == 16'h0) begin
                if ((c.mode == pit_pkg::MODE_SWSTRB) || (c.mode == pit_pkg::MODE_HWSTRB)) begin
                  c.out = 1'b0;
                  c.run = 1'b0;
                end else begin
                  c.out = 1'b1;
                end
              end
            end
          end
        end
        c.trig = 1'b0;
      end
      // a low gate acts at once, not at the next counter clock
      if (!g && ((c.mode == pit_pkg::MODE_RATE) || (c.mode == pit_pkg::MODE_SQUARE))) begin
        c.out = 1'b1;
      end
      if (wr_go && (sel == pit_pkg::PORT_MODE) && (pick == i[1:0])) begin
        if (bus.data[pit_pkg::CW_ACC_LSB +: 2] == pit_pkg::ACC_LATCH) begin
          // a second latch before the first is read keeps the older value
          if (!c.lat_full) begin
            c.lat      = c.cnt;
            c.lat_full = 1'b1;
          end
        end else begin
          c.mode     = mnew;
          c.acc      = bus.data[pit_pkg::CW_ACC_LSB +: 2];
          c.bcd      = bus.data[pit_pkg::CW_BCD_BIT];
          c.wr_hi    = 1'b0;
          c.rd_hi    = 1'b0;
          c.lat_full = 1'b0;
          c.run      = 1'b0;
          c.ld_pend  = 1'b0;
          c.ld_rise  = 1'b0;
          c.have     = 1'b0;
          c.trig     = 1'b0;
          c.out      = (mnew != pit_pkg::MODE_TCINT);
        end
      end
      if (wr_go && (sel == i[1:0])) begin
        done = 1'b0;
        case (c.acc)
          pit_pkg::ACC_LSB: begin
            c.init = {8'h00, bus.data};
            done   = 1'b1;
          end
          pit_pkg::ACC_MSB: begin
            c.init = {bus.data, 8'h00};
            done   = 1'b1;
          end
          default: begin
            if (!c.wr_hi) begin
              c.init[7:0] = bus.data;
              c.wr_hi     = 1'b1;
              if (c.mode == pit_pkg::MODE_TCINT) begin
                c.run = 1'b0;
              end
            end else begin
              c.init[15:8] = bus.data;
              c.wr_hi      = 1'b0;
              done         = 1'b1;
            end
          end
        endcase
        if (done) begin
          c.ld_pend = 1'b1;
          c.ld_rise = 1'b0;
        end
      end
      // port 3 has no read path, so the mode word never reaches the bus
      if (rd_go && (sel == i[1:0])) begin
        v    = c.lat_full ? c.lat : c.cnt;
        last = 1'b1;
        case (c.acc)
          pit_pkg::ACC_LSB: d.dout = v[7:0];
          pit_pkg::ACC_MSB: d.dout = v[15:8];
          default: begin
            d.dout  = c.rd_hi ? v[15:8] : v[7:0];
            last    = c.rd_hi;
            c.rd_hi = !c.rd_hi;
          end
        endcase
        d.doe = 1'b1;
        if (last) begin
          c.lat_full = 1'b0;
        end
      end
      d.ch[i] = c;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      for (int i = 0; i < 3; i++) begin
        q.ch[i].acc <= pit_pkg::RST_ACC;
        q.ch[i].out <= pit_pkg::RST_OUT;
      end
    end else begin
      q <= d;
    end
  end

  assign bus.ddata    = q.dout;
  assign bus.ddata_oe = q.doe;
  assign ctr_out_o    = {q.ch[2].out, q.ch[1].out, q.ch[0].out};
endmodule

// [rtl/pit_host.sv]
// host controller: AXI4-Lite commands become port-bus cycles
`timescale 1ns/1ns
module pit_host (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  pit_bus_if.host          bus
);
  typedef struct packed {
    pit_pkg::pit_hstate_e st;
    logic [1:0]           tmr;
    logic                 aw_have;
    logic                 w_have;
    logic [3:0]           awaddr;
    logic [31:0]          wdata;
    logic                 wstrb0;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 cs_n;
    logic                 rd_n;
    logic                 wr_n;
    logic [1:0]           ps;
    logic [7:0]           hdata;
    logic                 hoe;
    logic                 is_rd;
    logic [7:0]           rbyte;
  } pit_host_s;

  pit_host_s q;
  pit_host_s d;

  always_comb begin
    d = q;
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    unique case (q.st)
      pit_pkg::H_IDLE: begin
      end
      pit_pkg::H_STRB: begin
        if (q.tmr == 2'h0) begin
          if (q.is_rd) begin
            d.rbyte = bus.data;
          end
          d.cs_n = 1'b1;
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          d.hoe  = 1'b0;
          d.st   = pit_pkg::H_RECOV;
          d.tmr  = 2'(pit_pkg::RECOV_CYC - 1);
        end else begin
          d.tmr = q.tmr - 2'h1;
        end
      end
      pit_pkg::H_RECOV: begin
        if (q.tmr == 2'h0) begin
          d.st = pit_pkg::H_IDLE;
        end else begin
          d.tmr = q.tmr - 2'h1;
        end
      end
    endcase
    // bytes go out in the order software issues them
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = pit_pkg::RESP_SLVERR;
      if ((d.awaddr == pit_pkg::ADDR_CMD) && (q.st == pit_pkg::H_IDLE)) begin
        d.bresp = pit_pkg::RESP_OKAY;
        if (d.wstrb0) begin
          d.is_rd = d.wdata[pit_pkg::CMD_READ_BIT];
          d.ps    = d.wdata[pit_pkg::CMD_PORT_LSB +: 2];
          d.hdata = d.wdata[pit_pkg::CMD_BYTE_LSB +: 8];
          d.hoe   = !d.is_rd;
          d.cs_n  = 1'b0;
          d.rd_n  = !d.is_rd;
          d.wr_n  = d.is_rd;
          d.st    = pit_pkg::H_STRB;
          d.tmr   = 2'(pit_pkg::STRB_CYC - 1);
        end
      end
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = pit_pkg::RESP_OKAY;
      d.rdata  = 32'h0;
      if (s_axi_araddr == pit_pkg::ADDR_STAT) begin
        d.rdata[pit_pkg::STAT_DATA_LSB +: 8] = q.rbyte;
        d.rdata[0] = (q.st != pit_pkg::H_IDLE);
      end else if (s_axi_araddr != pit_pkg::ADDR_CMD) begin
        d.rresp = pit_pkg::RESP_SLVERR;
      end
    end
    // no new write is taken while a port cycle runs
    d.awready = !d.aw_have && !d.bvalid && (d.st == pit_pkg::H_IDLE);
    d.wready  = !d.w_have && !d.bvalid && (d.st == pit_pkg::H_IDLE);
    d.arready = !d.rvalid;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q      <= '0;
      q.st   <= pit_pkg::H_IDLE;
      q.cs_n <= 1'b1;
      q.rd_n <= 1'b1;
      q.wr_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_arready      = q.arready;
  assign s_axi_rvalid       = q.rvalid;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rdata        = q.rdata;
  assign bus.cs_n           = q.cs_n;
  assign bus.rd_n           = q.rd_n;
  assign bus.wr_n           = q.wr_n;
  assign bus.port_select_lo = q.ps[0];
  assign bus.port_select_hi = q.ps[1];
  assign bus.hdata          = q.hdata;
  assign bus.hdata_oe       = q.hoe;
endmodule

// [rtl/pit_pkg.sv]
// shared constants and types for the interval timer
package pit_pkg;
  localparam logic [1:0] PORT_CNT2 = 2'h2;
  localparam logic [1:0] PORT_MODE = 2'h3;
  localparam int CW_PICK_LSB = 6;
  localparam int CW_ACC_LSB  = 4;
  localparam int CW_MODE_LSB = 1;
  localparam int CW_BCD_BIT  = 0;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LSB   = 2'h1;
  localparam logic [1:0] ACC_MSB   = 2'h2;
  localparam logic [1:0] ACC_BOTH  = 2'h3;
  localparam logic [2:0] MODE_TCINT  = 3'h0;
  localparam logic [2:0] MODE_ONESHT = 3'h1;
  localparam logic [2:0] MODE_RATE   = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SWSTRB = 3'h4;
  localparam logic [2:0] MODE_HWSTRB = 3'h5;
  localparam logic [1:0] RST_ACC = ACC_BOTH;
  localparam logic       RST_OUT = 1'b0;
  localparam logic [3:0] ADDR_CMD  = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam int CMD_BYTE_LSB  = 0;
  localparam int CMD_PORT_LSB  = 8;
  localparam int CMD_READ_BIT  = 16;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_NS    = 100;
  localparam int STRB_NS   = 200;
  localparam int RECOV_NS  = 200;
  localparam int STRB_CYC  = (STRB_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_STRB  = 3'b010,
    H_RECOV = 3'b100
  } pit_hstate_e;

  typedef struct packed {
    logic [2:0]  mode;
    logic        bcd;
    logic [1:0]  acc;
    logic [15:0] cnt;
    logic [15:0] init;
    logic [15:0] lat;
    logic        lat_full;
    logic        wr_hi;
    logic        rd_hi;
    logic        ld_pend;
    logic        ld_rise;
    logic        have;
    logic        gate;
    logic        trig;
    logic        run;
    logic        first;
    logic        out;
  } pit_chan_s;
endpackage

// [rtl/pit_sync.sv]
// two-flop synchroniser for counter clock and gate pins
`timescale 1ns/1ns
module pit_sync #(
  parameter int W = 6
) (
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // the first stage may be metastable, so only the second stage reads it
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stage;
  } pit_sync_s;

  pit_sync_s q;
  pit_sync_s d;

  always_comb begin
    d       = q;
    d.meta  = d_i;
    d.stage = q.meta;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.stage;
endmodule

// [testbench/pit_bus_props.sv]
// concurrent checks on the port bus joining host and device
`timescale 1ns/1ns
module pit_bus_props (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       port_select_lo,
  input wire logic       port_select_hi,
  input wire logic [7:0] hdata,
  input wire logic       hdata_oe,
  input wire logic       ddata_oe
);
  logic [1:0] port;
  assign port = {port_select_hi, port_select_lo};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_RD_ANSWER: assert property ($fell(rd_n) && !cs_n && port != 2'h3 |-> ##1 ddata_oe)
    else $error("device did not drive read data");
  AST_PORT3_SILENT: assert property ($fell(rd_n) && port == 2'h3 |-> ##1 !ddata_oe [*3])
    else $error("device drove data on mode port read");
  AST_RD_RELEASE: assert property ($rose(rd_n) |-> ##1 !ddata_oe)
    else $error("device held bus after read");
  AST_NO_FIGHT: assert property (!(hdata_oe && ddata_oe))
    else $error("host and device drive together");
  AST_ONE_STROBE: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  AST_WR_WIDTH: assert property ($fell(wr_n) |-> !wr_n [*2] ##1 wr_n)
    else $error("write strobe width wrong");
  AST_RD_WIDTH: assert property ($fell(rd_n) |-> !rd_n [*2] ##1 rd_n)
    else $error("read strobe width wrong");
  AST_RECOV: assert property ($rose(wr_n) || $rose(rd_n) |-> (wr_n && rd_n) [*2])
    else $error("strobe recovery too short");
  AST_HDATA_HELD: assert property (!wr_n && $past(!wr_n) |-> $stable(hdata) && $stable(port))
    else $error("data or port changed in write");
  AST_DRIVE_ON_WRITE: assert property (!wr_n |-> hdata_oe && !cs_n)
    else $error("write strobe without driven data");
endmodule

// [testbench/programmable_interval_timer_tb.sv]
// self-checking bench: host and device joined over the port bus
`timescale 1ns/1ns
module programmable_interval_timer_tb;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [3:0]  awaddr    = 4'h0;
  logic [3:0]  araddr    = 4'h0;
  logic [31:0] wdata     = 32'h0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  ctr_clk   = 3'h0;
  logic [2:0]  gate      = 3'h3;
  logic [2:0]  ctr_out;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  pit_bus_if pit_bus_if_inst ();
  pit_host pit_host_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(pit_bus_if_inst));
  pit_device pit_device_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(pit_bus_if_inst),
    .ctr_clk_i(ctr_clk), .gate_i(gate), .ctr_out_o(ctr_out));
  pit_bus_props pit_bus_props_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .cs_n(pit_bus_if_inst.cs_n), .rd_n(pit_bus_if_inst.rd_n), .wr_n(pit_bus_if_inst.wr_n),
    .port_select_lo(pit_bus_if_inst.port_select_lo),
    .port_select_hi(pit_bus_if_inst.port_select_hi), .hdata(pit_bus_if_inst.hdata),
    .hdata_oe(pit_bus_if_inst.hdata_oe), .ddata_oe(pit_bus_if_inst.ddata_oe));

  always #50 sys_clk_i = ~sys_clk_i;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // whole run needs well under this many cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) num_errors++;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) num_errors++;
  endtask

  task automatic pw(input logic [1:0] p, input logic [7:0] b);
    logic [1:0] r;
    axi_wr(pit_pkg::ADDR_CMD, {22'h0, p, b}, r);
  endtask

  // port read, then poll status until the captured byte is ready
  task automatic pr(input logic [1:0] p, output logic [7:0] b);
    logic [1:0]  r;
    logic [31:0] d;
    axi_wr(pit_pkg::ADDR_CMD, {15'h0, 1'b1, 6'h0, p, 8'h0}, r);
    d = 32'h1;
    for (int i = 0; i < 20 && d[0] !== 1'b0; i++) begin
      axi_rd(pit_pkg::ADDR_STAT, d, r);
    end
    b = d[pit_pkg::STAT_DATA_LSB +: 8];
  endtask

  task automatic rd16(input logic [1:0] p, output logic [15:0] v);
    pr(p, v[7:0]);
    pr(p, v[15:8]);
  endtask

  task automatic cw(input logic [1:0] c, input logic [1:0] a, input logic [2:0] m, input logic b);
    pw(pit_pkg::PORT_MODE, {c, a, m, b});
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // counter clock well below a quarter of the system clock, as the syncers need
  task automatic clk1(input int c);
    @(posedge sys_clk_i);
    ctr_clk[c] <= 1'b1;
    waitc(4);
    ctr_clk[c] <= 1'b0;
    waitc(6);
  endtask

  task automatic setg(input int c, input logic v);
    @(posedge sys_clk_i);
    gate[c] <= v;
    waitc(5);
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  b;
    axi_rd(4'h8, d, r);
    chk("unmapped rresp", 32'(r), 32'(pit_pkg::RESP_SLVERR));
    chk("unmapped rdata", d, 32'h0);
    axi_wr(pit_pkg::ADDR_STAT, 32'h0, r);
    chk("status write bresp", 32'(r), 32'(pit_pkg::RESP_SLVERR));
    pr(pit_pkg::PORT_MODE, b);
    chk("mode port read", 32'(b), 32'hff);
  endtask

  task automatic t_square();
    int   hi;
    int   rises;
    logic prev;
    for (int n = 4; n <= 5; n++) begin
      cw(2'h0, pit_pkg::ACC_LSB, pit_pkg::MODE_SQUARE, 1'b0);
      pw(2'h0, 8'(n));
      repeat (3) clk1(0);
      hi = 0;
      rises = 0;
      prev = ctr_out[0];
      for (int i = 0; i < 2 * n; i++) begin
        clk1(0);
        hi += int'(ctr_out[0] === 1'b1);
        rises += int'(ctr_out[0] === 1'b1 && prev === 1'b0);
        prev = ctr_out[0];
      end
      chk("square high clocks", 32'(hi), 32'(2 * ((n + 1) / 2)));
      chk("square rises", 32'(rises), 32'h2);
    end
    for (int i = 0; i < 6 && ctr_out[0] !== 1'b0; i++) clk1(0);
    setg(0, 1'b0);
    chk("gate low forces high", 32'(ctr_out[0]), 32'h1);
    setg(0, 1'b1);
  endtask

  task automatic t_swstrb();
    logic [15:0] v;
    int          first;
    int          lows;
    for (int b = 0; b < 2; b++) begin
      setg(1, 1'b1);
      cw(2'h1, pit_pkg::ACC_BOTH, pit_pkg::MODE_SWSTRB, 1'(b));
      waitc(8);
      chk("strobe idle level", 32'(ctr_out[1]), 32'h1);
      pw(2'h1, 8'h0);
      pw(2'h1, 8'h0);
      repeat (3) clk1(1);
      // low nibble set on purpose: latch must ignore it
      cw(2'h1, pit_pkg::ACC_LATCH, 3'h7, 1'b1);
      repeat (2) clk1(1);
      rd16(2'h1, v);
      chk("latched count", 32'(v), (b == 1) ? 32'h9998 : 32'hfffe);
      setg(1, 1'b0);
      repeat (2) clk1(1);
      rd16(2'h1, v);
      chk("held count", 32'(v), (b == 1) ? 32'h9996 : 32'hfffc);
    end
    setg(1, 1'b1);
    pw(2'h1, 8'h3);
    pw(2'h1, 8'h0);
    first = 0;
    lows = 0;
    for (int i = 1; i <= 8; i++) begin
      clk1(1);
      if (ctr_out[1] === 1'b0) begin
        lows++;
        if (first == 0) first = i;
      end
    end
    chk("strobe position", 32'(first), 32'h4);
    chk("strobe width", 32'(lows), 32'h1);
  endtask

  task automatic t_hwstrb();
    int first;
    int lows;
    cw(2'h2, pit_pkg::ACC_LSB, pit_pkg::MODE_HWSTRB, 1'b0);
    pw(2'h2, 8'h4);
    repeat (2) clk1(2);
    chk("no strobe untriggered", 32'(ctr_out[2]), 32'h1);
    setg(2, 1'b1);
    repeat (2) clk1(2);
    setg(2, 1'b0);
    clk1(2);
    setg(2, 1'b1);
    first = 0;
    lows = 0;
    for (int i = 1; i <= 8; i++) begin
      clk1(2);
      if (ctr_out[2] === 1'b0) begin
        lows++;
        if (first == 0) first = i;
      end
    end
    chk("retrigger delay", 32'(first), 32'h5);
    chk("retrigger pulses", 32'(lows), 32'h1);
    // one-shot: gate already high, so a low-high cycle is needed to fire
    cw(2'h2, pit_pkg::ACC_LSB, pit_pkg::MODE_ONESHT, 1'b0);
    pw(2'h2, 8'h3);
    clk1(2);
    setg(2, 1'b0);
    clk1(2);
    setg(2, 1'b1);
    clk1(2);
    chk("one-shot low after trigger", 32'(ctr_out[2]), 32'h0);
    repeat (3) clk1(2);
    chk("one-shot end", 32'(ctr_out[2]), 32'h1);
    // terminal-count mode: a lone first byte must freeze the count
    cw(2'h2, pit_pkg::ACC_BOTH, pit_pkg::MODE_TCINT, 1'b0);
    pw(2'h2, 8'h3);
    pw(2'h2, 8'h0);
    repeat (2) clk1(2);
    pw(2'h2, 8'h2);
    repeat (3) clk1(2);
    chk("first byte stops count", 32'(ctr_out[2]), 32'h0);
    pw(2'h2, 8'h0);
    repeat (3) clk1(2);
    chk("count restarts on last byte", 32'(ctr_out[2]), 32'h1);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    waitc(2);
    t_bus();
    t_square();
    t_swstrb();
    t_hwstrb();
    wrap_up();
  end
endmodule
